//--- hdl/dac_update_gate_and_irq.v
/*
  Update pacing, hardware gate and pulsed shareable interrupt for the
  analog output update group, with an APB register slave.
  Assumes gate and external pacer pins are asynchronous; interrupt
  lines are resolved outside from irqOut and irqOeN (low = driving).
*/
`include "dac_update_gate_defines.vh"

module dac_update_gate_and_irq (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire gateIn,
  input wire pacerIn,
  output reg updateStrobe,
  output reg [7:0] updateMask,
  output reg [5:0] irqOut,
  output reg [5:0] irqOeN
);
  localparam [4:0] TICK_LAST = `TICK_LAST_CNT;
  localparam [4:0] PULSE_LAST = `PULSE_LAST_CNT;
  localparam IRQ_IDLE = 1'b0;
  localparam IRQ_PULSE = 1'b1;

  // control fields
  reg pacerEn_reg;
  reg extSel_reg;
  reg extRise_reg;
  reg gateEn_reg;
  reg gateNeg_reg;
  reg single_reg;
  reg [2:0] irqSel_reg;
  reg [14:0] period_reg;
  reg [7:0] chMask_reg;

  // pacer state
  reg [14:0] count_reg;
  reg [4:0] tick_reg;
  reg loaded_reg;
  reg pacerPrev_reg;
  reg [2:0] chanPtr_reg;

  // interrupt state
  reg irqState_reg;
  reg [4:0] pulseCnt_reg;
  reg [5:0] irqLine_reg;
  reg pend_reg;

  wire gateSync;
  wire pacerSync;

  in_sync #(.RESET_VAL(1'b0)) gateSyncInst (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(gateIn),
    .syncOut(gateSync)
  );

  in_sync #(.RESET_VAL(1'b1)) pacerSyncInst (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(pacerIn),
    .syncOut(pacerSync)
  );

  // gate evaluated on its synchronised level only
  wire gateLevelOk = gateSync ^ gateNeg_reg;
  wire gateActive = ~gateEn_reg | gateLevelOk;

  wire intMode = pacerEn_reg & ~extSel_reg;
  wire extMode = pacerEn_reg & extSel_reg;

  // internal pacer runs only while gate active; otherwise frozen
  wire running = intMode & loaded_reg & gateActive;
  wire tickDone = running & (tick_reg == TICK_LAST);
  // count of one on a finished tick is the last tick
  wire expire = tickDone & (count_reg == 15'h0001);
  wire loadEvt = intMode & ~loaded_reg & gateActive;
  wire intEvent = loadEvt | expire;

  // external pacer edge detect on synchronised level
  wire riseEdge = pacerSync & ~pacerPrev_reg;
  wire fallEdge = ~pacerSync & pacerPrev_reg;
  wire extEdge = extRise_reg ? riseEdge : fallEdge;
  wire extEvent = extMode & gateActive & extEdge;

  // internal and external modes are never both active
  wire updEvent = intEvent | extEvent;

  // register access decode
  wire apbAccess = psel & penable;
  wire apbDone = apbAccess & pready;
  wire wrDone = apbDone & pwrite;
  wire addrOk = (paddr == `ADDR_CTRL) | (paddr == `ADDR_PERIOD) |
                (paddr == `ADDR_CHMASK) | (paddr == `ADDR_STATUS) |
                (paddr == `ADDR_ACK) | (paddr == `ADDR_COUNT);
  wire wrCtrl = wrDone & (paddr == `ADDR_CTRL);
  wire wrPeriod = wrDone & (paddr == `ADDR_PERIOD);
  wire wrMask = wrDone & (paddr == `ADDR_CHMASK);
  wire wrAck = wrDone & (paddr == `ADDR_ACK);

  // period clamp to legal range
  reg [14:0] periodNext;
  always @* begin
    if (pwdata[31:15] != 17'h00000) begin
      periodNext = `PERIOD_MAX;
    end else if (pwdata[14:0] > `PERIOD_MAX) begin
      periodNext = `PERIOD_MAX;
    end else if (pwdata[14:0] < `PERIOD_MIN) begin
      periodNext = `PERIOD_MIN;
    end else begin
      periodNext = pwdata[14:0];
    end
  end

  // next selected channel for single-channel mode
  reg [2:0] chanNext;
  reg chanFound;
  reg [2:0] cand;
  integer i;
  always @* begin
    chanNext = chanPtr_reg;
    chanFound = 1'b0;
    cand = 3'h0;
    // search wraps once around the mask
    for (i = 1; i <= 8; i = i + 1) begin
      cand = chanPtr_reg + i[2:0];
      if (!chanFound && chMask_reg[cand]) begin
        chanNext = cand;
        chanFound = 1'b1;
      end
    end
  end

  reg [7:0] maskNext;
  always @* begin
    if (single_reg) begin
      maskNext = chanFound ? (8'h01 << chanNext) : 8'h00;
    end else begin
      maskNext = chMask_reg;
    end
  end

  // interrupt line decode: 1..6 select a line, 0 disables
  reg [5:0] lineDec;
  always @* begin
    case (irqSel_reg)
      3'h1: lineDec = 6'h01;
      3'h2: lineDec = 6'h02;
      3'h3: lineDec = 6'h04;
      3'h4: lineDec = 6'h08;
      3'h5: lineDec = 6'h10;
      3'h6: lineDec = 6'h20;
      default: lineDec = 6'h00;
    endcase
  end

  wire irqEnabled = (lineDec != 6'h00);
  wire irqReq = updEvent & irqEnabled;
  wire pulseEnd = (irqState_reg == IRQ_PULSE) & (pulseCnt_reg == PULSE_LAST);

  // control registers
  // writes to status and count are dropped without error
  always @(posedge sys_clk) begin
    if (srst) begin
      pacerEn_reg <= 1'b0;
      extSel_reg <= 1'b0;
      extRise_reg <= 1'b0;
      gateEn_reg <= 1'b0;
      gateNeg_reg <= 1'b0;
      single_reg <= 1'b0;
      irqSel_reg <= 3'h0;
      period_reg <= `PERIOD_RESET;
      chMask_reg <= `CHMASK_RESET;
    end else begin
      if (wrCtrl) begin
        pacerEn_reg <= pwdata[`CTRL_PACER_EN];
        extSel_reg <= pwdata[`CTRL_EXT_SEL];
        extRise_reg <= pwdata[`CTRL_EXT_RISE];
        gateEn_reg <= pwdata[`CTRL_GATE_EN];
        gateNeg_reg <= pwdata[`CTRL_GATE_NEG];
        single_reg <= pwdata[`CTRL_SINGLE];
        irqSel_reg <= pwdata[`CTRL_IRQ_MSB:`CTRL_IRQ_LSB];
      end
      if (wrPeriod) begin
        period_reg <= periodNext;
      end
      if (wrMask) begin
        chMask_reg <= pwdata[7:0];
      end
    end
  end

  // internal pacer counter
  always @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= `PERIOD_RESET;
      tick_reg <= 5'h00;
      loaded_reg <= 1'b0;
    end else if (!intMode) begin
      loaded_reg <= 1'b0;
      tick_reg <= 5'h00;
    end else if (loadEvt) begin
      count_reg <= period_reg;
      tick_reg <= 5'h00;
      loaded_reg <= 1'b1;
    end else if (running) begin
      if (tickDone) begin
        tick_reg <= 5'h00;
        if (count_reg == 15'h0001) begin
          count_reg <= period_reg;
        end else begin
          count_reg <= count_reg - 15'h0001;
        end
      end else begin
        tick_reg <= tick_reg + 5'h01;
      end
    end
    // gate inactive: count and tick hold their value
  end

  // external pacer history and channel pointer
  always @(posedge sys_clk) begin
    if (srst) begin
      pacerPrev_reg <= 1'b1;
      chanPtr_reg <= 3'h7;
    end else begin
      pacerPrev_reg <= pacerSync;
      if (updEvent && single_reg && chanFound) begin
        chanPtr_reg <= chanNext;
      end
    end
  end

  // update strobe and channel mask
  always @(posedge sys_clk) begin
    if (srst) begin
      updateStrobe <= 1'b0;
      updateMask <= 8'h00;
    end else begin
      updateStrobe <= updEvent;
      updateMask <= updEvent ? maskNext : 8'h00;
    end
  end

  // pulsed interrupt then pending flag
  always @(posedge sys_clk) begin
    if (srst) begin
      irqState_reg <= IRQ_IDLE;
      pulseCnt_reg <= 5'h00;
      irqLine_reg <= 6'h00;
      irqOut <= 6'h00;
      irqOeN <= 6'h3F;
    end else begin
      // requests during a pulse are dropped
      case (irqState_reg)
        IRQ_IDLE: begin
          if (irqReq) begin
            irqState_reg <= IRQ_PULSE;
            pulseCnt_reg <= 5'h00;
            // line latched so a later select change cannot cut the pulse
            irqLine_reg <= lineDec;
            irqOut <= lineDec;
            irqOeN <= ~lineDec;
          end
        end
        IRQ_PULSE: begin
          if (pulseEnd) begin
            irqState_reg <= IRQ_IDLE;
            irqOut <= 6'h00;
            irqOeN <= 6'h3F;
          end else begin
            pulseCnt_reg <= pulseCnt_reg + 5'h01;
            irqOut <= irqLine_reg;
            irqOeN <= ~irqLine_reg;
          end
        end
        default: begin
          irqState_reg <= IRQ_IDLE;
          irqOut <= 6'h00;
          irqOeN <= 6'h3F;
        end
      endcase
    end
  end

  // pending flag: set at pulse end wins over acknowledge
  // software polls it on every board sharing the line
  always @(posedge sys_clk) begin
    if (srst) begin
      pend_reg <= 1'b0;
    end else if (pulseEnd) begin
      pend_reg <= 1'b1;
    end else if (wrAck) begin
      pend_reg <= 1'b0;
    end
  end

  // apb slave: one wait state, read data registered
  always @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apbAccess && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addrOk;
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          `ADDR_CTRL: begin
            prdata[`CTRL_PACER_EN] <= pacerEn_reg;
            prdata[`CTRL_EXT_SEL] <= extSel_reg;
            prdata[`CTRL_EXT_RISE] <= extRise_reg;
            prdata[`CTRL_GATE_EN] <= gateEn_reg;
            prdata[`CTRL_GATE_NEG] <= gateNeg_reg;
            prdata[`CTRL_SINGLE] <= single_reg;
            prdata[`CTRL_IRQ_MSB:`CTRL_IRQ_LSB] <= irqSel_reg;
          end
          `ADDR_PERIOD: prdata[14:0] <= period_reg;
          `ADDR_CHMASK: prdata[7:0] <= chMask_reg;
          `ADDR_STATUS: begin
            prdata[`STAT_PEND] <= pend_reg;
            prdata[`STAT_GATE] <= gateActive;
            prdata[`STAT_RUN] <= running;
          end
          `ADDR_COUNT: prdata[14:0] <= count_reg;
          default: prdata <= 32'h00000000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // dac_update_gate_and_irq

//--- hdl/dac_update_gate_defines.vh
/*
  Constants for the analog output update gate and interrupt block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
// Summary of operation
// - software enable makes gate input count
// - gate acts on its level, not edges
// - positive gate: update only while high
// - negative gate: update only while low
// - inactive gate freezes internal pacer count
// - active again: resume count, no reload
// - external pacer: edges ignored while gated
// - pacer period 20 to 25500 microsecond ticks
// - update all selected or one per event
// - interrupt on each update when enabled, unless a pulse is already running
// - level choice 3,5,7,10,11,15 enables interrupts
// - interrupts off after power-up
// - interrupt line released when not requesting
// - pulse line, then set pending flag
// - load updates, each zero updates, repeat
// - external edge selectable, falling default
// - pacer disabled after power-up
`ifndef DAC_UPDATE_GATE_DEFINES_VH
`define DAC_UPDATE_GATE_DEFINES_VH

`define ADDR_CTRL 12'h000
`define ADDR_PERIOD 12'h004
`define ADDR_CHMASK 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_ACK 12'h010
`define ADDR_COUNT 12'h014

`define CTRL_PACER_EN 0
`define CTRL_EXT_SEL 1
`define CTRL_EXT_RISE 2
`define CTRL_GATE_EN 3
`define CTRL_GATE_NEG 4
`define CTRL_SINGLE 5
`define CTRL_IRQ_LSB 8
`define CTRL_IRQ_MSB 10

`define STAT_PEND 0
`define STAT_GATE 1
`define STAT_RUN 2

`define CTRL_RESET 32'h00000000
`define PERIOD_MIN 15'h0014
`define PERIOD_MAX 15'h639C
`define PERIOD_RESET 15'h0014
`define CHMASK_RESET 8'hFF

`define CLK_PERIOD_NS 50
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define IRQ_PULSE_NS 500
`define IRQ_PULSE_CYCLES (`IRQ_PULSE_NS / `CLK_PERIOD_NS)
`define TICK_LAST_CNT 5'h13
`define PULSE_LAST_CNT 5'h09

`endif

//--- hdl/in_sync.v
/*
  Two-stage synchroniser for one asynchronous input level.
  Assumes the caller reads only syncOut.
*/
module in_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire sys_clk,
  input wire srst,
  input wire asyncIn,
  output reg syncOut
);
  reg meta_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule // in_sync

//--- verification/dac_update_gate_and_irq_assertions.sv
/*
  Port checker for the update gate and interrupt block.
  Assumes one clock and a synchronous active-high reset.
*/
module dac_update_gate_and_irq_assertions (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire updateStrobe,
  input wire [7:0] updateMask,
  input wire [5:0] irqOut,
  input wire [5:0] irqOeN
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  line_release_a: assert property (irqOeN == ~irqOut)
    else $error("line enable not tied to line level");
  pulse_len_a: assert property ($rose(|irqOut) |=>
    (|irqOut)[*8] ##1 (|irqOut) ##1 !(|irqOut))
    else $error("interrupt pulse length wrong");
  irq_on_update_a: assert property ($rose(|irqOut) |-> updateStrobe)
    else $error("interrupt pulse without update");
  one_line_a: assert property ($onehot0(irqOut))
    else $error("more than one line driven");
  mask_idle_a: assert property (!updateStrobe |-> updateMask == 8'h00)
    else $error("mask shown without update");
  reset_quiet_a: assert property ($fell(srst) |-> irqOeN == 6'h3F && !updateStrobe)
    else $error("outputs active after reset");
  strobe_pulse_a: assert property (updateStrobe |=> !updateStrobe)
    else $error("update strobe too long");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // dac_update_gate_and_irq_assertions

bind dac_update_gate_and_irq dac_update_gate_and_irq_assertions i_chk (.sys_clk(sys_clk),
  .srst(srst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .updateStrobe(updateStrobe), .updateMask(updateMask), .irqOut(irqOut), .irqOeN(irqOeN));

//--- verification/ext_signal_src.sv
/*
  Far-side model: gate level, external pacer bursts, shared lines.
  Assumes the bench calls setGate and burst; lines have pull-downs;
  pins change by non-blocking assignment right after a rising edge.
*/
module ext_signal_src (
  input wire sys_clk,
  output logic gateIn,
  output logic pacerIn,
  input wire [5:0] irqOut,
  input wire [5:0] irqOeN,
  output wire [5:0] irqLine
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_CYC = 27;
  // released line falls to its pull-down
  assign irqLine = irqOut & ~irqOeN;
  initial begin
    gateIn = 1'b0;
    pacerIn = 1'b1;
  end
  task setGate(input logic lvl);
    repeat (6) @(posedge sys_clk);
    gateIn <= lvl;
  endtask
  // pacer stands still high between bursts
  task burst(input int n);
    repeat (n) begin
      repeat (HALF_CYC) @(posedge sys_clk);
      pacerIn <= 1'b0;
      repeat (HALF_CYC) @(posedge sys_clk);
      pacerIn <= 1'b1;
    end
  endtask
endmodule // ext_signal_src

//--- verification/testbench.sv
/*
  Self-checking bench for the update gate and interrupt block.
  Assumes the far-side model drives gate and pacer pins.
*/
`include "dac_update_gate_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, updateStrobe, gateIn, pacerIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m, p;
  logic [7:0] updateMask;
  logic [5:0] irqOut, irqOeN, irqLine, irqSeen;
  logic [64:0] apbQ[$];
  logic [64:0] note;
  logic [7:0] maskQ[$];
  int errors, comparisons, cycles, seed, k;
  dac_update_gate_and_irq i_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gateIn(gateIn), .pacerIn(pacerIn),
    .updateStrobe(updateStrobe), .updateMask(updateMask), .irqOut(irqOut), .irqOeN(irqOeN));
  ext_signal_src i_src (.sys_clk(sys_clk), .gateIn(gateIn), .pacerIn(pacerIn), .irqOut(irqOut),
    .irqOeN(irqOeN), .irqLine(irqLine));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] mk,
      input logic [31:0] e, input logic er);
    apbQ.push_back({er, mk, e});
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e);
    apb(1'b0, a, 32'h0, mk, e, 1'b0);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    irqSeen <= irqSeen | irqLine;
    if (pready === 1'b1 && apbQ.size() > 0) begin
      note = apbQ.pop_front();
      check({31'h0, pslverr}, {31'h0, note[64]}, "bus error");
      check(prdata & note[63:32], note[31:0], "read data");
    end
    if (updateStrobe === 1'b1) begin
      if (maskQ.size() == 0)
        check(32'h1, 32'h0, "extra update");
      else
        check({24'h0, updateMask}, {24'h0, maskQ.pop_front()}, "update mask");
    end
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    seed = 32'h60DE6963;
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0};
    {errors, comparisons, cycles, irqSeen} = 0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(`ADDR_CTRL, 32'hFFFFFFFF, `CTRL_RESET);
    rd(`ADDR_PERIOD, 32'h7FFF, {17'h0, `PERIOD_RESET});
    p = 32'h18 + {$random(seed)} % 32'hFE8;
    apb(1'b0, p[11:0], 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    p = 32'h14 + {$random(seed)} % 32'h6389;
    wr(`ADDR_PERIOD, p);
    rd(`ADDR_PERIOD, 32'h7FFF, p);
    wr(`ADDR_PERIOD, 32'h7530);
    rd(`ADDR_PERIOD, 32'h7FFF, {17'h0, `PERIOD_MAX});
    wr(`ADDR_PERIOD, 32'h5);
    rd(`ADDR_PERIOD, 32'h7FFF, {17'h0, `PERIOD_MIN});
    m = $random(seed);
    wr(`ADDR_CHMASK, m);
    for (k = 0; k < 8; k++) begin
      repeat (3) maskQ.push_back(m[7:0]);
      wr(`ADDR_CTRL, 32'h1 | (k << `CTRL_IRQ_LSB));
      repeat (900) @(posedge sys_clk);
      wr(`ADDR_CTRL, 32'h0);
      rd(`ADDR_STATUS, 32'h1, {31'h0, k > 0 && k < 7});
      wr(`ADDR_ACK, 32'h0);
      rd(`ADDR_STATUS, 32'h1, 32'h0);
      check(maskQ.size(), 32'h0, "paced updates");
      check({26'h0, irqSeen}, (32'h1 << (k > 6 ? 6 : k)) - 32'h1, "lines");
    end
    for (k = 0; k < 2; k++) begin
      i_src.setGate(k[0]);
      wr(`ADDR_CTRL, 32'h9 | (k << `CTRL_GATE_NEG));
      repeat (500) @(posedge sys_clk);
      repeat (2) maskQ.push_back(m[7:0]);
      i_src.setGate(!k[0]);
      repeat (200) @(posedge sys_clk);
      i_src.setGate(k[0]);
      repeat (600 + {$random(seed)} % 400) @(posedge sys_clk);
      i_src.setGate(!k[0]);
      repeat (250) @(posedge sys_clk);
      i_src.setGate(k[0]);
      wr(`ADDR_CTRL, 32'h0);
      check(maskQ.size(), 32'h0, "gated updates");
    end
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(`ADDR_CHMASK, 32'hFF, {24'h0, `CHMASK_RESET});
    wr(`ADDR_CHMASK, 32'h29);
    i_src.setGate(1'b0);
    wr(`ADDR_CTRL, 32'h2B);
    i_src.burst(3);
    maskQ = '{8'h01, 8'h08, 8'h20, 8'h01, 8'h08, 8'h20, 8'h01};
    i_src.setGate(1'b1);
    i_src.burst(4);
    repeat (10) @(posedge sys_clk);
    wr(`ADDR_CTRL, 32'h2F);
    i_src.burst(3);
    i_src.setGate(1'b0);
    i_src.burst(2);
    repeat (10) @(posedge sys_clk);
    check(maskQ.size(), 32'h0, "edge updates");
    report_and_stop();
  end
endmodule // testbench
